// ===== include/smc_defs.svh
// Constants of the static memory controller: decode values, codes, timing counts
// Assumes inclusion by bare name from design files
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

`define SMC_BANK_SEL0     2'h0
`define SMC_BANK_SEL1     2'h1
`define SMC_HTRANS_SEQ    2'h3
`define SMC_HSIZE_BYTE    2'h0
`define SMC_HSIZE_HALF    2'h1
`define SMC_HSIZE_WORD    2'h2
`define SMC_QUAD_LAST     2'h3
`define SMC_WAIT_MIN      5'h02
`define SMC_WE_DLY_MIN    4'h1
`define SMC_SYNC_LAST     2'h1
`define SMC_HALF_STEP     20'h00001

`endif

// ===== include/smc_pkg.sv
// Types of the static memory controller: state codes and state records
// Assumes nothing beyond a SystemVerilog compiler
package smc_pkg;

  typedef enum logic [6:0] {
    SMC_IDLE = 7'h01,
    SMC_ADDR = 7'h02,
    SMC_ACC  = 7'h04,
    SMC_CAP  = 7'h08,
    SMC_PIPE = 7'h10,
    SMC_RESP = 7'h20,
    SMC_ERR  = 7'h40
  } smc_state_t;

  typedef struct packed {
    smc_state_t  st;
    logic        bank;
    logic        wr;
    logic [1:0]  size;
    logic        b0;
    logic        two;
    logic        first;
    logic        fast;
    logic        burst;
    logic [19:0] ha;
    logic [19:0] eaddr;
    logic [31:0] wdata;
    logic [15:0] rlo;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic        act;
    logic [1:0]  cs;
    logic        oe_n;
    logic        we_n;
    logic [15:0] dout;
    logic        doe_n;
    logic [1:0]  bls_n;
    logic [15:0] s1;
    logic [15:0] s2;
    logic [1:0]  pc;
  } smc_ctl_t;

  typedef struct packed {
    logic [4:0] cnt;
  } smc_tmr_t;

endpackage : smc_pkg

// ===== include/smc_tmr_if.sv
// Link between access sequencer and access timer
// Assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface smc_tmr_if;
  logic       start;
  logic [4:0] wait_cnt;
  logic [3:0] oe_dly;
  logic [3:0] we_dly;
  logic       oe_go;
  logic       we_go;
  logic       last;

  modport ctrl  (output start, output wait_cnt, output oe_dly, output we_dly,
                 input oe_go, input we_go, input last);
  modport timer (input start, input wait_cnt, input oe_dly, input we_dly,
                 output oe_go, output we_go, output last);
endinterface : smc_tmr_if
`default_nettype wire

// ===== verilog/smc_timer.sv
// Access timer: counts cycles of one chip-select access, times strobes and end
// Assumes start pulses in the cycle before chip-select goes active
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"
module smc_timer
  import smc_pkg::*;
(
  input  wire logic  i_clock,
  input  wire logic  i_sys_rst,
  input  wire logic  i_clk_en,
  smc_tmr_if.timer   tmr
);

  smc_tmr_t   q;
  smc_tmr_t   d;
  logic [4:0] total;
  logic [4:0] nxt;
  logic [3:0] we_min;

  // Zero wait still costs two cycles
  assign total  = (tmr.wait_cnt == 5'h00) ? `SMC_WAIT_MIN : tmr.wait_cnt;
  assign nxt    = q.cnt + 5'h01;
  // Write strobe never shares the first chip-select cycle
  assign we_min = (tmr.we_dly == 4'h0) ? `SMC_WE_DLY_MIN : tmr.we_dly;

  assign tmr.oe_go = (nxt >= {1'b0, tmr.oe_dly});
  assign tmr.we_go = (nxt >= {1'b0, we_min});
  assign tmr.last  = (nxt >= total);

  always_comb begin
    d = q;
    if (tmr.start) begin
      d.cnt = 5'h00;
    end else if (q.cnt != 5'h1F) begin
      d.cnt = nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      q <= '0;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

endmodule : smc_timer
`default_nettype wire

// ===== verilog/smc_ctrl.sv
// Static memory controller: bus slave mapping two external memory banks
// Assumes a pipelined system bus on i_clock and asynchronous 16-bit memories
//
// Function
// - Chip-select polarity programmable, active low default
// - Address bits 27:26 select bank 0 or 1
// - External data bus is 16 bits only
// - Word read stalls bus until both halves
// - Wait count per bank up to 31 cycles
// - Zero wait count still gives two cycles
// - Slow reads use read wait, writes second wait
// - Output enable delayed after chip-select, up to 15
// - Output enable drops together with chip-select
// - Bursts of four reads hold select and enable
// - Fast burst reads use second wait register
// - Burst ends at quad boundary, index 11
// - Index 00 slow, 01, 10 and 11 fast
// - Write enable delayed after chip-select, up to 15
// - Zero write delay still waits one cycle
// - Address reaches memory two cycles after request
// - Read data returns two cycles after capture
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"
module smc_ctrl
  import smc_pkg::*;
(
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  input  wire logic             i_clk_en,
  input  wire logic             i_hsel,
  input  wire logic [31:0]      i_haddr,
  input  wire logic [1:0]       i_htrans,
  input  wire logic             i_hwrite,
  input  wire logic [2:0]       i_hsize,
  input  wire logic             i_hready,
  input  wire logic [31:0]      i_hwdata,
  output logic                  o_hreadyout,
  output logic [1:0]            o_hresp,
  output logic [31:0]           o_hrdata,
  input  wire logic [1:0]       i_cs_pol_high,
  input  wire logic [1:0]       i_burst_en,
  input  wire logic [1:0][4:0]  i_read_wait,
  input  wire logic [1:0][4:0]  i_write_burst_wait,
  input  wire logic [1:0][3:0]  i_oe_delay_field,
  input  wire logic [1:0][3:0]  i_we_delay_field,
  output logic [19:0]           o_ext_addr,
  output logic [1:0]            o_ext_cs,
  output logic                  o_ext_oe_n,
  output logic                  o_ext_we_n,
  output logic [1:0]            o_ext_bls_n,
  input  wire logic [15:0]      i_ext_data,
  output logic [15:0]           o_ext_data,
  output logic                  o_ext_data_oe_n
);

  localparam smc_ctl_t RST = '{st: SMC_IDLE, hready: 1'b1, cs: 2'h3, oe_n: 1'b1, we_n: 1'b1,
                               doe_n: 1'b1, bls_n: 2'h3, default: '0};

  smc_ctl_t    q;
  smc_ctl_t    d;
  logic        accept;
  logic        cont;
  logic        tmr_start;
  logic [15:0] wd_half;
  logic [31:0] wd;

  smc_tmr_if tmr ();

  smc_timer u_timer (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .tmr       (tmr)
  );

  // Per-bank timing fields for the access in flight
  assign tmr.start    = tmr_start;
  assign tmr.wait_cnt = (q.wr || q.fast) ? i_write_burst_wait[q.bank] : i_read_wait[q.bank];
  assign tmr.oe_dly   = i_oe_delay_field[q.bank];
  assign tmr.we_dly   = i_we_delay_field[q.bank];

  assign accept = i_hsel && i_hready && i_htrans[1];

  // Next read continues an open burst only up to the quad boundary
  assign cont = q.burst && accept && !i_hwrite && (i_htrans == `SMC_HTRANS_SEQ) &&
                (i_haddr[27:26] == {1'b0, q.bank}) &&
                (i_haddr[20:1] == (q.ha + `SMC_HALF_STEP));

  assign wd      = q.first ? i_hwdata : q.wdata;
  assign wd_half = q.ha[0] ? wd[31:16] : wd[15:0];

  always_comb begin
    d = q;
    tmr_start = 1'b0;
    // Two-stage synchroniser on the external data pins
    d.s1 = i_ext_data;
    d.s2 = q.s1;
    case (q.st)
      SMC_IDLE: begin
        d.hready = 1'b1;
        d.hresp  = 1'b0;
        if (!cont) begin
          d.act   = 1'b0;
          d.oe_n  = 1'b1;
          d.burst = 1'b0;
        end
        if (accept && !q.hresp) begin
          d.hready = 1'b0;
          d.wr     = i_hwrite;
          d.size   = i_hsize[1:0];
          d.b0     = i_haddr[0];
          d.ha     = i_haddr[20:1];
          d.two    = (i_hsize[1:0] == `SMC_HSIZE_WORD);
          d.first  = 1'b1;
          d.fast   = cont;
          d.bank   = i_haddr[26];
          if ((i_haddr[27:26] == `SMC_BANK_SEL0) || (i_haddr[27:26] == `SMC_BANK_SEL1)) begin
            d.st = SMC_ADDR;
          end else begin
            d.hresp = 1'b1;
            d.st    = SMC_ERR;
          end
        end
      end
      SMC_ADDR: begin
        // Address and select go out two cycles after the request
        d.eaddr   = q.ha;
        d.act     = 1'b1;
        tmr_start = 1'b1;
        d.first   = 1'b0;
        d.st      = SMC_ACC;
        if (q.wr) begin
          d.wdata = wd;
          d.dout  = wd_half;
          d.doe_n = 1'b0;
          if (q.size == `SMC_HSIZE_BYTE) begin
            d.bls_n = q.b0 ? 2'h1 : 2'h2;
          end else begin
            d.bls_n = 2'h0;
          end
        end else begin
          d.bls_n = 2'h0;
          d.oe_n  = q.oe_n && (tmr.oe_dly != 4'h0);
        end
      end
      SMC_ACC: begin
        if (!q.wr && tmr.oe_go) begin
          d.oe_n = 1'b0;
        end
        if (q.wr && tmr.we_go) begin
          d.we_n = 1'b0;
        end
        if (tmr.last) begin
          d.we_n = 1'b1;
          if (q.wr) begin
            d.act   = 1'b0;
            d.oe_n  = 1'b1;
            d.doe_n = 1'b1;
            d.bls_n = 2'h3;
            if (q.two) begin
              d.two = 1'b0;
              d.ha  = q.ha + `SMC_HALF_STEP;
              d.st  = SMC_ADDR;
            end else begin
              d.st = SMC_RESP;
            end
          end else begin
            // Burst keeps select and enable unless at the quad boundary
            d.burst = i_burst_en[q.bank] && (q.ha[1:0] != `SMC_QUAD_LAST);
            if (!d.burst) begin
              d.act   = 1'b0;
              d.oe_n  = 1'b1;
              d.bls_n = 2'h3;
            end
            d.pc = 2'h0;
            d.st = SMC_CAP;
          end
        end
      end
      SMC_CAP: begin
        d.pc = q.pc + 2'h1;
        if (q.pc == `SMC_SYNC_LAST) begin
          if (q.two) begin
            d.rlo  = q.s2;
            d.two  = 1'b0;
            d.ha   = q.ha + `SMC_HALF_STEP;
            d.fast = q.burst;
            d.st   = SMC_ADDR;
          end else begin
            d.hrdata = (q.size == `SMC_HSIZE_WORD) ? {q.s2, q.rlo} : {q.s2, q.s2};
            d.st     = SMC_PIPE;
          end
        end
      end
      SMC_PIPE: begin
        d.st = SMC_RESP;
      end
      SMC_RESP: begin
        d.hready = 1'b1;
        d.st     = SMC_IDLE;
      end
      SMC_ERR: begin
        d.hready = 1'b1;
        d.hresp  = 1'b1;
        d.st     = SMC_IDLE;
      end
      default: begin
        d = RST;
      end
    endcase
    // Select level per bank with programmable polarity
    for (int b = 0; b < 2; b++) begin
      d.cs[b] = (d.act && (d.bank == b[0])) ^ !i_cs_pol_high[b];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      q <= RST;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  assign o_hreadyout     = q.hready;
  assign o_hresp         = {1'b0, q.hresp};
  assign o_hrdata        = q.hrdata;
  assign o_ext_addr      = q.eaddr;
  assign o_ext_cs        = q.cs;
  assign o_ext_oe_n      = q.oe_n;
  assign o_ext_we_n      = q.we_n;
  assign o_ext_bls_n     = q.bls_n;
  assign o_ext_data      = q.dout;
  assign o_ext_data_oe_n = q.doe_n;

endmodule : smc_ctrl
`default_nettype wire

// ===== bench/smc_ctrl_asserts.sv
// Checker of bus response and strobe timing of the static memory controller
// Assumes binding to smc_ctrl on its single clock
`timescale 1ns/1ps
`default_nettype none
module smc_ctrl_asserts (
  input wire logic            i_clock, i_sys_rst, i_clk_en, i_hsel, i_hready, i_hwrite, o_hreadyout,
  input wire logic            o_ext_oe_n, o_ext_we_n, o_ext_data_oe_n,
  input wire logic [31:0]     i_haddr,
  input wire logic [1:0]      i_htrans, o_hresp, i_cs_pol_high, i_burst_en, o_ext_cs,
  input wire logic [1:0][4:0] i_read_wait, i_write_burst_wait,
  input wire logic [1:0][3:0] i_oe_delay_field, i_we_delay_field,
  input wire logic [19:0]     o_ext_addr
);
  logic       ok_q, wr_q, bk_q;
  logic [5:0] len_q;
  wire [1:0] act = ~(o_ext_cs ^ i_cs_pol_high) & {2{ok_q}};
  wire       a   = |act;
  wire       acc = i_clk_en & i_hsel & i_hready & i_htrans[1] & o_hreadyout & ~o_hresp[0];
  wire [4:0] w   = wr_q ? i_write_burst_wait[bk_q] : i_read_wait[bk_q];
  wire [4:0] ex  = (w == 5'h00) ? 5'h02 : w;
  wire [3:0] wd  = i_we_delay_field[act[1]];
  // Cycles the select has been active
  always_ff @(posedge i_clock) begin
    ok_q  <= !i_sys_rst;
    len_q <= a ? len_q + 6'h01 : 6'h00;
    if (acc) begin
      wr_q <= i_hwrite;
      bk_q <= i_haddr[26];
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  property p_bank; acc && !i_haddr[27] |-> ##2 act == ($past(i_haddr[26], 2) ? 2'h2 : 2'h1); endproperty
  a_bank: assert property (p_bank) else $error("wrong bank selected");
  property p_err; acc && i_haddr[27] |=> o_hresp == 2'h1 && !o_hreadyout ##1 o_hresp == 2'h1 && o_hreadyout;
  endproperty
  a_err: assert property (p_err) else $error("bad error response");
  property p_addr; acc && !i_haddr[27] |-> ##2 o_ext_addr == $past(i_haddr[20:1], 2); endproperty
  a_addr: assert property (p_addr) else $error("address late or wrong");
  property p_len; $fell(a) && !i_burst_en[bk_q] |-> len_q == {1'b0, ex}; endproperty
  a_len: assert property (p_len) else $error("access length wrong");
  property p_oe; $fell(o_ext_oe_n) |-> len_q == {2'h0, i_oe_delay_field[act[1]]}; endproperty
  a_oe: assert property (p_oe) else $error("output enable delay wrong");
  property p_we; $fell(o_ext_we_n) |-> len_q == ((wd == 4'h0) ? 6'h01 : {2'h0, wd}); endproperty
  a_we: assert property (p_we) else $error("write enable delay wrong");
  property p_oe_end; $rose(o_ext_oe_n) |-> $fell(a); endproperty
  a_oe_end: assert property (p_oe_end) else $error("output enable not released with select");
  property p_idle; !a |-> o_ext_oe_n && o_ext_we_n && o_ext_data_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("strobe active while idle");
  // A burst keeps the select held past the last access
  property p_rdlat; $rose(o_hreadyout) && !wr_q && o_hresp == 2'h0 |->
    $past(a, 5) && (i_burst_en[bk_q] || !$past(a, 4)); endproperty
  a_rdlat: assert property (p_rdlat) else $error("read return latency wrong");
  c_burst: cover property ($fell(a) && i_burst_en[bk_q] && len_q > {1'b0, i_read_wait[bk_q]});
  c_err: cover property (acc && i_haddr[27]);
  c_write: cover property ($fell(o_ext_we_n));
endmodule : smc_ctrl_asserts
bind smc_ctrl smc_ctrl_asserts chk (.i_clock, .i_sys_rst, .i_clk_en, .i_hsel, .i_hready, .i_hwrite, .o_hreadyout,
  .o_ext_oe_n, .o_ext_we_n, .o_ext_data_oe_n, .i_haddr, .i_htrans, .o_hresp, .i_cs_pol_high, .i_burst_en,
  .o_ext_cs, .i_read_wait, .i_write_burst_wait, .i_oe_delay_field, .i_we_delay_field, .o_ext_addr);
`default_nettype wire

// ===== bench/smc_mem_model.sv
// Behavioural asynchronous 16-bit memory serving both banks
// Assumes active-high selects worked out by the bench, active-low byte lanes
`timescale 1ns/1ps
`default_nettype none
module smc_mem_model (
  input wire logic        i_clock, i_oe_n, i_we_n,
  input wire logic [1:0]  i_sel, i_bls_n,
  input wire logic [19:0] i_addr,
  input wire logic [15:0] i_data,
  output logic [15:0]     o_data
);
  logic [15:0] mem [0:127];
  logic [15:0] last_q = 16'h0000;
  wire  [6:0]  ix = {i_sel[1], i_addr[5:0]};
  // Released bus shows no stale value
  assign o_data = (|i_sel && !i_oe_n) ? mem[ix] : ~last_q;
  initial for (int i = 0; i < 128; i++) mem[i] = 16'hC000 | 16'(i);
  always @(posedge i_clock) begin
    last_q <= o_data;
    if (|i_sel && !i_we_n) begin
      if (!i_bls_n[0]) mem[ix][7:0] <= i_data[7:0];
      if (!i_bls_n[1]) mem[ix][15:8] <= i_data[15:8];
    end
  end
endmodule : smc_mem_model
`default_nettype wire

// ===== bench/smc_ctrl_bench.sv
// Self-checking bench of the static memory controller
// Assumes smc_ctrl, its checker and smc_mem_model compiled before
`timescale 1ns/1ps
`default_nettype none
`define SMC_CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module smc_ctrl_bench;
  logic            i_clock = 0, rst = 1, hsel = 0, hwrite = 0, hrdy, oe_n, we_n, doe_n;
  logic [31:0]     haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]      htrans = 2'h0, pol = 2'h0, ben = 2'h0, hresp, cs, bls_n;
  logic [2:0]      hsize = 3'h0;
  logic [1:0][4:0] rw = 10'h000, ww = 10'h000;
  logic [1:0][3:0] oed = 8'h00, wed = 8'h00;
  logic [19:0]     ea;
  logic [15:0]     din, dout;
  int              errors = 0, compares = 0, cyc = 0;
  initial forever #5 i_clock = ~i_clock;
  smc_ctrl uut (.i_clock, .i_sys_rst(rst), .i_clk_en(1'b1), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hrdy), .i_hwdata(hwdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .o_hrdata(hrdata), .i_cs_pol_high(pol), .i_burst_en(ben), .i_read_wait(rw), .i_write_burst_wait(ww),
    .i_oe_delay_field(oed), .i_we_delay_field(wed), .o_ext_addr(ea), .o_ext_cs(cs), .o_ext_oe_n(oe_n),
    .o_ext_we_n(we_n), .o_ext_bls_n(bls_n), .i_ext_data(din), .o_ext_data(dout), .o_ext_data_oe_n(doe_n));
  smc_mem_model mem (.i_clock, .i_oe_n(oe_n), .i_we_n(we_n), .i_sel(~(cs ^ pol)), .i_bls_n(bls_n),
    .i_addr(ea), .i_data(dout), .o_data(din));
  task automatic wrap_up;
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("ERROR %0t: timeout", $time);
      wrap_up();
    end
  end
  // One transfer: address held until taken, then data phase until ready
  task automatic xfer(input logic w, input logic [2:0] sz, input logic [31:0] a, input logic [31:0] wd);
    @(posedge i_clock);
    hsel <= 1'b1; hwrite <= w; hsize <= sz; haddr <= a; htrans <= 2'h2;
    do @(posedge i_clock); while (hrdy !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge i_clock); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic t_timing;
    logic [4:0]  wt [4] = '{5'h00, 5'h03, 5'h05, 5'h1F};
    logic [3:0]  dl [4] = '{4'h0, 4'h0, 4'h4, 4'hF};
    logic [31:0] a, d;
    for (int i = 0; i < 4; i++) begin
      rw[i%2] <= wt[i]; ww[i%2] <= wt[i]; oed[i%2] <= dl[i]; wed[i%2] <= dl[i];
      a = {5'h00, 1'(i), 26'h0000000} | 32'(i * 8);
      d = 32'h9A5C31E0 ^ 32'(i * 32'h01010101);
      xfer(1'b1, 3'h2, a, d);
      xfer(1'b0, 3'h2, a, 32'h0);
      `SMC_CHK(rd, d)
      xfer(1'b0, 3'h1, a + 32'h2, 32'h0);
      `SMC_CHK(rd, {2{d[31:16]}})
    end
  endtask : t_timing
  task automatic t_bytes;
    xfer(1'b1, 3'h0, 32'h41, 32'h00007E00);
    xfer(1'b1, 3'h0, 32'h40, 32'h0000005B);
    xfer(1'b0, 3'h1, 32'h40, 32'h0);
    `SMC_CHK(rd, 32'h7E5B7E5B)
  endtask : t_bytes
  task automatic t_error;
    xfer(1'b0, 3'h2, 32'h08000040, 32'h0);
    `SMC_CHK(hresp, 2'h1)
    xfer(1'b0, 3'h1, 32'h40, 32'h0);
    `SMC_CHK(rd, 32'h7E5B7E5B)
  endtask : t_error
  task automatic t_burst;
    ben <= 2'h2; rw[1] <= 5'h06; ww[1] <= 5'h02; oed[1] <= 4'h3;
    xfer(1'b0, 3'h2, 32'h04000050, 32'h0);
    `SMC_CHK(rd, 32'hC069C068)
    xfer(1'b0, 3'h2, 32'h04000054, 32'h0);
    `SMC_CHK(rd, 32'hC06BC06A)
  endtask : t_burst
  task automatic t_polarity;
    `SMC_CHK(cs, 2'h3)
    rst <= 1'b1; pol <= 2'h3;
    repeat (4) @(posedge i_clock);
    rst <= 1'b0;
    repeat (2) @(posedge i_clock);
    `SMC_CHK(cs, 2'h0)
    xfer(1'b0, 3'h1, 32'h40, 32'h0);
    `SMC_CHK(rd, 32'h7E5B7E5B)
  endtask : t_polarity
  initial begin
    repeat (4) @(posedge i_clock);
    rst <= 1'b0;
    @(posedge i_clock);
    t_timing();
    t_bytes();
    t_error();
    t_burst();
    t_polarity();
    wrap_up();
  end
endmodule : smc_ctrl_bench
`default_nettype wire
